//--- logic/line_unit_map.svh
`ifndef LINE_UNIT_MAP_SVH
`define LINE_UNIT_MAP_SVH

// register addresses on the host register port
`define LU_ADDR_OUTPUT_CONTROL 8'h00
`define LU_ADDR_INPUT_STATUS   8'h01

// field positions inside the output control register
`define LU_BIT_EQUALIZER_BYPASS   0
`define LU_BIT_SEND_ALL_ONES      1
`define LU_BIT_CODER_DISABLE      2
`define LU_BIT_BUILD_OUT_DISABLE  3
`define LU_BIT_REMOTE_LOOP_SELECT 4
`define LU_BIT_LOCAL_LOOP_SELECT  5
`define LU_DRIVE_BITS             6

// field positions inside the input status register
`define LU_BIT_DRIVE_MONITOR_ALARM 0
`define LU_BIT_RECOVERY_LOCK_LOST  1
`define LU_BIT_LINE_SIGNAL_LOST    2
`define LU_SCAN_BITS               3

// reset values
`define LU_DRIVE_RESET 6'h00
`define LU_SCAN_RESET  3'h0
`define LU_DATA_RESET  8'h00

`endif

//--- logic/line_unit_pkg.sv
`default_nettype none

`include "line_unit_map.svh"

package line_unit_pkg;

	// six command levels toward the line unit
	typedef logic [`LU_DRIVE_BITS-1:0] drive_t;

	// three condition levels from the line unit
	typedef logic [`LU_SCAN_BITS-1:0] scan_t;

	// loop-back selection formed by remote and local select bits
	typedef enum logic [1:0] {
		LOOP_NORMAL,
		LOOP_REMOTE,
		LOOP_ANALOG_LOCAL,
		LOOP_DIGITAL_LOCAL
	} loop_mode_t;

endpackage

`default_nettype wire

//--- logic/scan_if.sv
`timescale 1ns/100ps
`default_nettype none

// carries the raw pin levels to the synchroniser and the clean levels back
interface scan_if #(
	parameter int WIDTH = 3
);
	logic [WIDTH-1:0] raw;
	logic [WIDTH-1:0] clean;

	modport sync (input raw, output clean);
	modport core (output raw, input clean);
endinterface

`default_nettype wire

//--- logic/scan_sync.sv
`timescale 1ns/100ps
`default_nettype none

`include "line_unit_map.svh"

module scan_sync #(
	parameter int WIDTH = 3
) (
	// clock and reset
	input  wire logic CLK,
	input  wire logic SRST,
	// pin levels in, settled levels out
	scan_if.sync      scan
);

	logic [WIDTH-1:0] stage1_reg;
	logic [WIDTH-1:0] stage2_reg;
	logic [WIDTH-1:0] stage3_reg;
	logic [WIDTH-1:0] clean_reg;
	logic [WIDTH-1:0] stage1_next;
	logic [WIDTH-1:0] stage2_next;
	logic [WIDTH-1:0] stage3_next;
	logic [WIDTH-1:0] clean_next;

	////////////////////////////////////////////////////////////////////////
	// elaboration check
	generate
		if (WIDTH < 1) begin : g_bad_width
			$error("scan_sync width must be at least one");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// three stage chain; a level is taken once stages two and three agree
	always_comb begin
		stage1_next = scan.raw;
		stage2_next = stage1_reg;
		stage3_next = stage2_reg;
		clean_next  = clean_reg;
		for (int i = 0; i < WIDTH; i++) begin
			if (stage2_reg[i] == stage3_reg[i]) begin
				clean_next[i] = stage3_reg[i]; // R13
			end
		end
	end

	// registers only
	always_ff @(posedge CLK) begin
		if (SRST) begin
			stage1_reg <= '0;
			stage2_reg <= '0;
			stage3_reg <= '0;
			clean_reg  <= '0;
		end else begin
			stage1_reg <= stage1_next;
			stage2_reg <= stage2_next;
			stage3_reg <= stage3_next;
			clean_reg  <= clean_next;
		end
	end

	assign scan.clean = clean_reg;

endmodule

`default_nettype wire

//--- logic/line_unit_drive_scan.sv
`timescale 1ns/100ps
`default_nettype none

`include "line_unit_map.svh"

// Functional notes
// R1: writable control register sets six output pins toward the line unit.
// R2: read-only status register shows levels of three line unit input pins.
// R3: equalizer bypass bit 1 drives pin high, turning receive equalizer off.
// R4: all-ones bit 1 drives pin high so line unit sends all ones.
// R5: coder disable bit 1 drives pin high, disabling line unit coding.
// R6: build-out bit 1 drives pin high for an unshaped square wave.
// R7: software sets build-out above 225 feet of cable, clears it below.
// R8: remote and local loop bits together pick one of four loop modes.
// R9: line unit flags no bipolar signal over 128 +-32 bits; reported here.
// R10: line unit flags lost clock recovery lock; reported in status.
// R11: line unit flags loss of signal; reported in status.
// R12: pins follow control bits right after the write, cleared at reset.
// R13: status inputs synchronised before reads; reading has no side effects.

module line_unit_drive_scan #(
	parameter int ADDR_W = 8,
	parameter int DATA_W = 8
) (
	// clock and reset
	input  wire logic              CLK,
	input  wire logic              SRST,
	// host register port
	input  wire logic [ADDR_W-1:0] REG_ADDR,
	input  wire logic              REG_WR,
	input  wire logic              REG_RD,
	input  wire logic [DATA_W-1:0] REG_WDATA,
	output var  logic [DATA_W-1:0] REG_RDATA,
	output var  logic              REG_ACK,
	// command pins toward the line unit
	output var  logic              EQUALIZER_BYPASS,
	output var  logic              SEND_ALL_ONES,
	output var  logic              CODER_DISABLE,
	output var  logic              BUILD_OUT_DISABLE,
	output var  logic              REMOTE_LOOP_SELECT,
	output var  logic              LOCAL_LOOP_SELECT,
	// condition pins from the line unit
	input  wire logic              DRIVE_MONITOR_ALARM,
	input  wire logic              RECOVERY_LOCK_LOST,
	input  wire logic              LINE_SIGNAL_LOST,
	// decoded loop-back mode for the rest of the framer
	output var  line_unit_pkg::loop_mode_t LOOP_MODE
);

	////////////////////////////////////////////////////////////////////////
	// declarations

	line_unit_pkg::drive_t     drive_reg;
	line_unit_pkg::drive_t     drive_next;
	logic [DATA_W-1:0]         rdata_reg;
	logic [DATA_W-1:0]         rdata_next;
	logic                      ack_reg;
	logic                      ack_next;
	line_unit_pkg::loop_mode_t loop_reg;
	line_unit_pkg::loop_mode_t loop_next;
	line_unit_pkg::scan_t      scan_view;
	logic                      hit_control;
	logic                      hit_status;
	logic                      access;

	// access decode terms
	logic                      wr_control;
	logic                      rd_only;
	logic                      rd_control;
	logic                      rd_status;
	logic [DATA_W-1:0]         drive_word;
	logic [DATA_W-1:0]         scan_word;

	scan_if #(.WIDTH(`LU_SCAN_BITS)) scan ();

	////////////////////////////////////////////////////////////////////////
	// elaboration checks

	generate
		if (DATA_W < `LU_DRIVE_BITS) begin : g_bad_data
			$error("data width too narrow for the control register");
		end
		if (ADDR_W < 1 || ADDR_W > 8) begin : g_bad_addr
			$error("address width must lie between one and eight");
		end
		if (`LU_ADDR_INPUT_STATUS >= (1 << ADDR_W)) begin : g_bad_map
			$error("status address lies outside the address range");
		end
		if (DATA_W < `LU_SCAN_BITS) begin : g_bad_scan
			$error("data width too narrow for the status register");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// status pin synchroniser

	// pin levels enter the chain in their fixed status bit order
	always_comb begin
		scan.raw = `LU_SCAN_RESET;
		scan.raw[`LU_BIT_DRIVE_MONITOR_ALARM] = DRIVE_MONITOR_ALARM; // R9
		scan.raw[`LU_BIT_RECOVERY_LOCK_LOST]  = RECOVERY_LOCK_LOST;  // R10
		scan.raw[`LU_BIT_LINE_SIGNAL_LOST]    = LINE_SIGNAL_LOST;    // R11
	end

	scan_sync #(
		.WIDTH (`LU_SCAN_BITS)
	) u_scan_sync (
		.CLK  (CLK),
		.SRST (SRST),
		.scan (scan)
	);

	// settled levels, the only view software ever gets
	assign scan_view = scan.clean; // R13

	////////////////////////////////////////////////////////////////////////
	// address decode

	// both strobes together count as a write; the read result is dropped
	assign access      = REG_WR | REG_RD;
	assign hit_control = (REG_ADDR == ADDR_W'(`LU_ADDR_OUTPUT_CONTROL));
	assign hit_status  = (REG_ADDR == ADDR_W'(`LU_ADDR_INPUT_STATUS));

	// one strobe per access kind; a write masks a read raised with it
	assign wr_control = REG_WR & hit_control; // R2
	assign rd_only    = REG_RD & ~REG_WR;
	assign rd_control = rd_only & hit_control;
	assign rd_status  = rd_only & hit_status;

	////////////////////////////////////////////////////////////////////////
	// register images on the data bus

	// upper bits of both registers read as zero
	always_comb begin
		drive_word                     = '0;
		drive_word[`LU_DRIVE_BITS-1:0] = drive_reg;
		scan_word                      = '0;
		scan_word[`LU_SCAN_BITS-1:0]   = scan_view; // R13
	end

	////////////////////////////////////////////////////////////////////////
	// control register and read path, next values

	// one answer per strobe; a write never disturbs the held read data
	always_comb begin
		drive_next = drive_reg;
		rdata_next = rdata_reg;
		ack_next   = access; // every strobe is answered one cycle later
		if (wr_control) begin
			drive_next = REG_WDATA[`LU_DRIVE_BITS-1:0]; // R1
		end
		if (rd_control) begin
			rdata_next = drive_word; // R1
		end else if (rd_status) begin
			rdata_next = scan_word; // R2 R13
		end else if (rd_only) begin
			rdata_next = '0; // unmapped read gives zero
		end
	end

	// registers only
	always_ff @(posedge CLK) begin
		if (SRST) begin
			drive_reg <= `LU_DRIVE_RESET; // R12
			rdata_reg <= `LU_DATA_RESET;
			ack_reg   <= 1'b0;
		end else begin
			drive_reg <= drive_next;
			rdata_reg <= rdata_next;
			ack_reg   <= ack_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// loop-back decode, next value

	// follows the select bits as they reach the pins
	always_comb begin
		case ({drive_next[`LU_BIT_REMOTE_LOOP_SELECT], drive_next[`LU_BIT_LOCAL_LOOP_SELECT]})
			2'b10: begin
				loop_next = line_unit_pkg::LOOP_REMOTE; // R8
			end
			2'b01: begin
				loop_next = line_unit_pkg::LOOP_ANALOG_LOCAL; // R8
			end
			2'b11: begin
				loop_next = line_unit_pkg::LOOP_DIGITAL_LOCAL; // R8
			end
			default: begin
				loop_next = line_unit_pkg::LOOP_NORMAL; // R8
			end
		endcase
	end

	// registers only
	always_ff @(posedge CLK) begin
		if (SRST) begin
			loop_reg <= line_unit_pkg::LOOP_NORMAL;
		end else begin
			loop_reg <= loop_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs

	// host port answer
	assign REG_RDATA = rdata_reg;
	assign REG_ACK   = ack_reg;

	// each pin is its control bit straight from the flop, high for one
	assign EQUALIZER_BYPASS   = drive_reg[`LU_BIT_EQUALIZER_BYPASS];   // R3 R12
	assign SEND_ALL_ONES      = drive_reg[`LU_BIT_SEND_ALL_ONES];      // R4 R12
	assign CODER_DISABLE      = drive_reg[`LU_BIT_CODER_DISABLE];      // R5 R12
	assign BUILD_OUT_DISABLE  = drive_reg[`LU_BIT_BUILD_OUT_DISABLE];  // R6 R12
	assign REMOTE_LOOP_SELECT = drive_reg[`LU_BIT_REMOTE_LOOP_SELECT]; // R8 R12
	assign LOCAL_LOOP_SELECT  = drive_reg[`LU_BIT_LOCAL_LOOP_SELECT];  // R8 R12

	// mode seen by the framer, aligned with the select pins
	assign LOOP_MODE = loop_reg;

endmodule

`default_nettype wire

//--- sim/line_unit_drive_scan_properties.sv
`timescale 1ns/100ps
`default_nettype none
module line_unit_drive_scan_properties #(
	parameter int ADDR_W = 8,
	parameter int DATA_W = 8
) (
	// clock and reset
	input wire logic              CLK,
	input wire logic              SRST,
	// host register port
	input wire logic [ADDR_W-1:0] REG_ADDR,
	input wire logic              REG_WR,
	input wire logic              REG_RD,
	input wire logic [DATA_W-1:0] REG_WDATA,
	input wire logic [DATA_W-1:0] REG_RDATA,
	input wire logic              REG_ACK,
	// line unit pins
	input wire logic              EQUALIZER_BYPASS,
	input wire logic              SEND_ALL_ONES,
	input wire logic              CODER_DISABLE,
	input wire logic              BUILD_OUT_DISABLE,
	input wire logic              REMOTE_LOOP_SELECT,
	input wire logic              LOCAL_LOOP_SELECT,
	input wire logic              DRIVE_MONITOR_ALARM,
	input wire logic              RECOVERY_LOCK_LOST,
	input wire logic              LINE_SIGNAL_LOST,
	input wire line_unit_pkg::loop_mode_t LOOP_MODE
);
	logic [5:0] pins;
	logic [2:0] scan;
	logic       wr_ctl;
	logic       rd_only;
	// gathered pins and decoded strobes
	assign pins = {LOCAL_LOOP_SELECT, REMOTE_LOOP_SELECT, BUILD_OUT_DISABLE, CODER_DISABLE,
		SEND_ALL_ONES, EQUALIZER_BYPASS};
	assign scan = {LINE_SIGNAL_LOST, RECOVERY_LOCK_LOST, DRIVE_MONITOR_ALARM};
	assign wr_ctl = REG_WR && REG_ADDR == '0;
	assign rd_only = REG_RD && !REG_WR;
	default clocking dc @(posedge CLK); endclocking
	default disable iff (SRST);
	////////////////////////////////////////
	a_drive_follows:
		assert property (wr_ctl |=> pins == $past(REG_WDATA[5:0]))
		else $error("pins differ from written value");
	a_loop_decode:
		assert property (wr_ctl |=> LOOP_MODE == $past(REG_WDATA[5:4]))
		else $error("loop mode wrong");
	a_pins_hold:
		assert property (!wr_ctl |=> $stable(pins))
		else $error("pins moved without write");
	a_ack_timing:
		assert property (1'b1 |=> REG_ACK == $past(REG_WR || REG_RD))
		else $error("ack timing wrong");
	a_ctrl_readback:
		assert property (rd_only && REG_ADDR == '0 |=> REG_RDATA == {2'b00, $past(pins)})
		else $error("control readback wrong");
	a_unmapped_zero:
		assert property (rd_only && REG_ADDR > 8'h01 |=> REG_RDATA == '0)
		else $error("unmapped read not zero");
	a_status_track:
		assert property ($stable(scan)[*6] ##0 (rd_only && REG_ADDR == 8'h01)
			|=> REG_RDATA == {5'h00, $past(scan)})
		else $error("status read wrong");
	a_write_keeps:
		assert property (REG_WR |=> $stable(REG_RDATA))
		else $error("write changed read data");
	a_reset_clear:
		assert property (disable iff (1'b0) SRST |=> pins == 6'h00 && !REG_ACK && REG_RDATA == '0)
		else $error("reset values wrong");
endmodule
bind line_unit_drive_scan line_unit_drive_scan_properties #(.ADDR_W(ADDR_W), .DATA_W(DATA_W))
	chk_u (.CLK(CLK), .SRST(SRST), .REG_ADDR(REG_ADDR), .REG_WR(REG_WR), .REG_RD(REG_RD),
	.REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .REG_ACK(REG_ACK),
	.EQUALIZER_BYPASS(EQUALIZER_BYPASS), .SEND_ALL_ONES(SEND_ALL_ONES),
	.CODER_DISABLE(CODER_DISABLE), .BUILD_OUT_DISABLE(BUILD_OUT_DISABLE),
	.REMOTE_LOOP_SELECT(REMOTE_LOOP_SELECT), .LOCAL_LOOP_SELECT(LOCAL_LOOP_SELECT),
	.DRIVE_MONITOR_ALARM(DRIVE_MONITOR_ALARM), .RECOVERY_LOCK_LOST(RECOVERY_LOCK_LOST),
	.LINE_SIGNAL_LOST(LINE_SIGNAL_LOST), .LOOP_MODE(LOOP_MODE));
`default_nettype wire

//--- sim/line_unit_model.sv
`timescale 1ns/100ps
`default_nettype none
module line_unit_model #(
	parameter int QUIET_BITS = 128
) (
	// bit clock and line conditions
	input  wire logic CLK,
	input  wire logic PULSE_SEEN,
	input  wire logic LOCK_FAIL,
	input  wire logic SIGNAL_FAIL,
	// condition pins
	output var  logic DRIVE_MONITOR_ALARM,
	output var  logic RECOVERY_LOCK_LOST,
	output var  logic LINE_SIGNAL_LOST
);
	int quiet_cnt = 0;
	// count bit periods without a bipolar pulse and raise the alarms
	always @(posedge CLK) begin
		quiet_cnt <= PULSE_SEEN ? 0 : quiet_cnt + 1;
		DRIVE_MONITOR_ALARM <= !PULSE_SEEN && quiet_cnt >= QUIET_BITS - 1;
		RECOVERY_LOCK_LOST <= LOCK_FAIL;
		LINE_SIGNAL_LOST <= SIGNAL_FAIL;
	end
	// quiet pins before the first bit period
	initial begin
		{DRIVE_MONITOR_ALARM, RECOVERY_LOCK_LOST, LINE_SIGNAL_LOST} = 3'h0;
	end
endmodule
`default_nettype wire

//--- sim/test_line_unit_drive_scan.sv
`timescale 1ns/100ps
`default_nettype none
module test_line_unit_drive_scan;
	logic       clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, d;
	logic       ack, pulse = 1'b1, lock_fail = 1'b0, sig_fail = 1'b0;
	wire  [5:0] pins;
	wire  [2:0] scan;
	line_unit_pkg::loop_mode_t mode;
	int         failures = 0, n_checks = 0, exp_ctrl = 0;
	// cable length above which software picks the unshaped square wave
	localparam int LONG_CABLE_FEET = 225;
	// clock
	initial begin
		forever #2.5 clk = ~clk;
	end
	line_unit_drive_scan dut_u (.CLK(clk), .SRST(srst), .REG_ADDR(addr), .REG_WR(wr), .REG_RD(rd),
		.REG_WDATA(wdata), .REG_RDATA(rdata), .REG_ACK(ack), .EQUALIZER_BYPASS(pins[0]),
		.SEND_ALL_ONES(pins[1]), .CODER_DISABLE(pins[2]), .BUILD_OUT_DISABLE(pins[3]),
		.REMOTE_LOOP_SELECT(pins[4]), .LOCAL_LOOP_SELECT(pins[5]), .DRIVE_MONITOR_ALARM(scan[0]),
		.RECOVERY_LOCK_LOST(scan[1]), .LINE_SIGNAL_LOST(scan[2]), .LOOP_MODE(mode));
	line_unit_model lu_u (.CLK(clk), .PULSE_SEEN(pulse), .LOCK_FAIL(lock_fail),
		.SIGNAL_FAIL(sig_fail), .DRIVE_MONITOR_ALARM(scan[0]), .RECOVERY_LOCK_LOST(scan[1]),
		.LINE_SIGNAL_LOST(scan[2]));
	////////////////////////////////////////
	// compare and count
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	// one strobe cycle, answer looked at in the following cycle
	task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] v);
		wr = w;
		rd = !w;
		addr = a;
		wdata = v;
		@(negedge clk);
		chk({7'h00, ack}, 8'h01);
	endtask
	// release strobes for n cycles
	task automatic idle(input int n);
		wr = 1'b0;
		rd = 1'b0;
		repeat (n) @(negedge clk);
		chk({7'h00, ack}, 8'h00);
	endtask
	task automatic finish_test;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	////////////////////////////////////////
	// main sequence
	initial begin
		void'($urandom(7));
		idle(2);
		srst = 1'b0;
		acc(1'b0, 8'h00, 8'h00);
		chk(rdata, 8'h00);
		chk({2'b00, pins}, 8'h00);
		idle(1);
		$display("test 1 done");
		for (int i = 0; i < 20; i++) begin
			d = (i < 4) ? 8'(i << 4) : 8'($urandom);
			exp_ctrl = d & 8'h3f;
			acc(1'b1, 8'h00, d);
			chk({2'b00, pins}, 8'(exp_ctrl));
			chk({6'h00, mode}, {6'h00, d[5:4]});
			acc(1'b0, 8'h00, 8'h00);
			chk(rdata, 8'(exp_ctrl));
		end
		idle(1);
		$display("test 2 done");
		acc(1'b1, 8'h01, 8'hff);
		acc(1'b1, 8'h5a, 8'hff);
		acc(1'b0, 8'h5a, 8'h00);
		chk(rdata, 8'h00);
		acc(1'b0, 8'h00, 8'h00);
		chk(rdata, 8'(exp_ctrl));
		// software choice of pulse shape from a short and a long cable
		for (int f = 100; f <= 300; f += 200) begin
			acc(1'b1, 8'h00, (f > LONG_CABLE_FEET) ? 8'h08 : 8'h00);
			chk({7'h00, pins[3]}, 8'(f > LONG_CABLE_FEET));
		end
		// both strobes at once: the write wins, read data stays
		wr = 1'b1;
		rd = 1'b1;
		wdata = 8'h15;
		@(negedge clk);
		chk({7'h00, ack}, 8'h01);
		chk({2'b00, pins}, 8'h15);
		chk(rdata, 8'(exp_ctrl));
		exp_ctrl = 8'h15;
		idle(1);
		$display("test 3 done");
		for (int k = 0; k < 8; k++) begin
			pulse = !k[0];
			lock_fail = k[1];
			sig_fail = k[2];
			idle(140);
			acc(1'b0, 8'h01, 8'h00);
			chk(rdata, 8'(k));
			acc(1'b0, 8'h01, 8'h00);
			chk(rdata, 8'(k));
		end
		$display("test 4 done");
		acc(1'b1, 8'h00, 8'h3f);
		srst = 1'b1;
		idle(2);
		srst = 1'b0;
		chk({2'b00, pins}, 8'h00);
		chk({6'h00, mode}, {6'h00, line_unit_pkg::LOOP_NORMAL});
		$display("test 5 done");
		finish_test();
	end
	// watchdog
	initial begin
		#100000;
		failures++;
		finish_test();
	end
endmodule
`default_nettype wire
